/* logic/ufbc_config.sv */
`timescale 1ns/100ps
`include "ufbc_params.svh"

module ufbc_config (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	// register bus
	input  wire ufbc_pkg::ufbc_axil_req_t bus_req,
	output ufbc_pkg::ufbc_axil_rsp_t      bus_rsp,
	// serial peer pins
	input  wire logic                     cts_n_pin,
	input  wire logic                     sync_clock_pin,
	output logic                          rts_n_pin,
	output logic                          rts_n_oe,
	// shift engines
	input  wire logic                     rx_buf_full,
	output ufbc_pkg::ufbc_frame_cfg_t     frame_cfg,
	output logic                          tx_start_allowed,
	output logic                          tx_change_pulse,
	output logic                          rx_sample_pulse,
	output logic                          baud_tick
);
	import ufbc_pkg::*;

	typedef struct packed {
		ufbc_axil_rsp_t  rsp;
		logic [7:0]      raddr;
		logic [7:0]      frame;
		logic [7:0]      ctrlb;
		logic [1:0]      flow;
		logic [3:0]      divh;
		logic [7:0]      divl;
		logic            ds;
		logic            reload;
		logic            cts_s1;
		logic            cts_s2;
		logic            sck_s1;
		logic            sck_s2;
		logic            sck_s3;
		ufbc_frame_cfg_t cfg;
		logic            tx_allowed;
		logic            tx_chg;
		logic            rx_smp;
		logic            rts_n;
		logic            rts_oe;
	} ufbc_state_t;

	ufbc_state_t st_q;
	ufbc_state_t st_d;
	logic        wr_go;
	logic        rd_go;
	logic [7:0]  rd_byte;
	ufbc_mode_t  mode;
	logic        sck_rise;
	logic        sck_fall;

	always_comb
	begin
		st_d = st_q;
		rd_byte = 8'h00;
		st_d.reload = 1'b0;
		st_d.tx_chg = 1'b0;
		st_d.rx_smp = 1'b0;
		st_d.rsp.awready = 1'b0;
		st_d.rsp.wready = 1'b0;
		st_d.rsp.arready = 1'b0;
		// cts crosses in through two flops, the sync clock through three
		st_d.cts_s1 = cts_n_pin;
		st_d.cts_s2 = st_q.cts_s1;
		st_d.sck_s1 = sync_clock_pin;
		st_d.sck_s2 = st_q.sck_s1;
		st_d.sck_s3 = st_q.sck_s2;

		// write: address and data are accepted together
		wr_go = st_q.rsp.awready && bus_req.awvalid && bus_req.wvalid;
		if (bus_req.bready && st_q.rsp.bvalid)
			st_d.rsp.bvalid = 1'b0;
		if (wr_go)
		begin
			st_d.rsp.bvalid = 1'b1;
			st_d.rsp.bresp = ufbc_mapped(bus_req.awaddr) ? `UFBC_RESP_OK : `UFBC_RESP_ERR;
			if (ufbc_mapped(bus_req.awaddr) && bus_req.wstrb[0])
			begin
				unique case (bus_req.awaddr[7:0])
					`UFBC_OFF_FRAME: st_d.frame = bus_req.wdata[7:0];
					`UFBC_OFF_CTRLB: st_d.ctrlb = bus_req.wdata[7:0] & `UFBC_CB_WMASK;
					`UFBC_OFF_FLOW:  st_d.flow = bus_req.wdata[1:0];
					`UFBC_OFF_DIVH:  st_d.divh = bus_req.wdata[3:0];
					`UFBC_OFF_DIVL:
					begin
						st_d.divl = bus_req.wdata[7:0];
						st_d.reload = 1'b1;
					end
					`UFBC_OFF_SPEED: st_d.ds = bus_req.wdata[`UFBC_SP_DS];
					default:         st_d.ds = st_q.ds;
				endcase
			end
		end
		else if (bus_req.awvalid && bus_req.wvalid && !st_q.rsp.bvalid && !st_q.rsp.awready)
		begin
			st_d.rsp.awready = 1'b1;
			st_d.rsp.wready = 1'b1;
		end

		// read: unmapped words answer zero with an error
		rd_go = st_q.rsp.arready && bus_req.arvalid;
		if (bus_req.rready && st_q.rsp.rvalid)
			st_d.rsp.rvalid = 1'b0;
		case (bus_req.araddr[7:0])
			`UFBC_OFF_FRAME: rd_byte = st_q.frame;
			`UFBC_OFF_CTRLB: rd_byte = st_q.ctrlb;
			`UFBC_OFF_FLOW:  rd_byte = {6'h00, st_q.flow};
			`UFBC_OFF_DIVH:  rd_byte = {4'h0, st_q.divh};
			`UFBC_OFF_DIVL:  rd_byte = st_q.divl;
			`UFBC_OFF_SPEED: rd_byte = {7'h00, st_q.ds};
			`UFBC_OFF_STAT:  rd_byte = {st_q.tx_allowed, st_q.rts_n, st_q.cts_s2,
				st_q.cfg.size_rsvd, st_q.cfg.data_bits};
			default:         rd_byte = 8'h00;
		endcase
		if (rd_go)
		begin
			st_d.rsp.rvalid = 1'b1;
			st_d.raddr = bus_req.araddr[7:0];
			st_d.rsp.rresp = ufbc_mapped(bus_req.araddr) ? `UFBC_RESP_OK : `UFBC_RESP_ERR;
			st_d.rsp.rdata = ufbc_mapped(bus_req.araddr) ? {24'h0, rd_byte} : 32'h0;
		end
		else if (bus_req.arvalid && !st_q.rsp.rvalid && !st_q.rsp.arready)
			st_d.rsp.arready = 1'b1;

		// frame settings handed to the shift engines
		mode = ufbc_mode_t'(st_q.frame[`UFBC_FF_MODE_HI:`UFBC_FF_MODE_LO]);
		st_d.cfg.mode = mode;
		st_d.cfg.data_bits = ufbc_char_bits({st_q.ctrlb[`UFBC_CB_SZTOP],
			st_q.frame[`UFBC_FF_SZ_HI:`UFBC_FF_SZ_LO]});
		st_d.cfg.size_rsvd = (st_d.cfg.data_bits == 4'h0);
		st_d.cfg.parity = st_q.frame[`UFBC_FF_PAR_HI:`UFBC_FF_PAR_LO];
		st_d.cfg.two_stop = st_q.frame[`UFBC_FF_STOP];
		st_d.cfg.tx_ninth_bit = st_q.ctrlb[`UFBC_CB_TX9];
		st_d.cfg.double_speed_sel = st_q.ds && (mode == UFBC_ASYNC);

		// handshake lines
		st_d.tx_allowed = !st_q.flow[`UFBC_FC_CTS] || !st_q.cts_s2;
		st_d.rts_oe = st_q.flow[`UFBC_FC_RTS];
		st_d.rts_n = st_q.flow[`UFBC_FC_RTS] ? rx_buf_full : 1'b1;

		// polarity is ignored outside sync mode, so a stale bit is harmless
		sck_rise = st_q.sck_s2 && !st_q.sck_s3;
		sck_fall = !st_q.sck_s2 && st_q.sck_s3;
		if (mode == UFBC_SYNC)
		begin
			st_d.tx_chg = st_q.frame[`UFBC_FF_POL] ? sck_fall : sck_rise;
			st_d.rx_smp = st_q.frame[`UFBC_FF_POL] ? sck_rise : sck_fall;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q <= '0;
			st_q.frame <= `UFBC_RST_FRAME;
			st_q.cfg.data_bits <= 4'h8;
			st_q.tx_allowed <= 1'b1;
			st_q.rts_n <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// sync mode keeps the prescaler; frames in flight see a reload as a glitch
	ufbc_baud_gen u_baud (
		.ref_clk          (ref_clk),
		.rstn             (rstn),
		.baud_divisor     ({st_q.divh, st_q.divl}),
		.reload           (st_q.reload),
		.mode             (st_q.cfg.mode),
		.double_speed_sel (st_q.cfg.double_speed_sel),
		.baud_tick        (baud_tick)
	);

	assign bus_rsp = st_q.rsp;
	assign frame_cfg = st_q.cfg;
	assign tx_start_allowed = st_q.tx_allowed;
	assign tx_change_pulse = st_q.tx_chg;
	assign rx_sample_pulse = st_q.rx_smp;
	assign rts_n_pin = st_q.rts_n;
	assign rts_n_oe = st_q.rts_oe;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	frame_len_a: assert property (
		st_q.cfg.data_bits == ufbc_char_bits($past({st_q.ctrlb[2], st_q.frame[2:1]})))
		else $error("frame length does not follow size code");

	edge_pol_a: assert property (
		st_q.tx_chg && !$past(st_q.frame[0]) |-> $past(st_q.sck_s2) && !$past(st_q.sck_s3))
		else $error("tx change not on rising edge with polarity zero");

	async_edge_a: assert property (
		st_q.frame[7:6] == 2'h0 |=> !st_q.tx_chg && !st_q.rx_smp)
		else $error("sync clock edges used in async mode");

	cts_pass_a: assert property (
		(!cts_n_pin && st_q.flow[1]) [*4] |-> st_q.tx_allowed)
		else $error("transmit held although cts is low");

	cts_block_a: assert property (
		st_q.flow[1] && st_q.cts_s2 |=> !st_q.tx_allowed)
		else $error("transmit allowed while cts is high");

	rts_off_a: assert property (
		!st_q.flow[0] |=> !st_q.rts_oe && st_q.rts_n)
		else $error("rts driven with receive handshake off");

	rts_full_a: assert property (
		st_q.flow[0] && rx_buf_full |=> st_q.rts_n && st_q.rts_oe)
		else $error("rts asserted while receive buffer full");

	div_high_a: assert property (
		st_q.rsp.rvalid && st_q.raddr == `UFBC_OFF_DIVH |-> st_q.rsp.rdata[31:4] == 28'h0)
		else $error("reserved divisor bits read nonzero");

	low_reload_a: assert property (
		wr_go && bus_req.wstrb[0] && bus_req.awaddr == 32'h10
		|=> st_q.reload && st_q.divl == $past(bus_req.wdata[7:0]) ##1 !st_q.reload)
		else $error("low divisor write did not reload once");

	ds_async_a: assert property (
		st_q.cfg.double_speed_sel |-> $past(st_q.frame[7:6]) == 2'h0 && $past(st_q.ds))
		else $error("double speed outside async mode");

endmodule : ufbc_config

/* logic/ufbc_params.svh */
`ifndef UFBC_PARAMS_SVH
`define UFBC_PARAMS_SVH

// register byte offsets on the bus
`define UFBC_OFF_FRAME   8'h00
`define UFBC_OFF_CTRLB   8'h04
`define UFBC_OFF_FLOW    8'h08
`define UFBC_OFF_DIVH    8'h0c
`define UFBC_OFF_DIVL    8'h10
`define UFBC_OFF_SPEED   8'h14
`define UFBC_OFF_STAT    8'h18

// reset values
`define UFBC_RST_FRAME   8'h06
`define UFBC_RST_CTRLB   8'h00
`define UFBC_RST_FLOW    2'h0
`define UFBC_RST_DIVH    4'h0
`define UFBC_RST_DIVL    8'h00

// field positions
`define UFBC_FF_POL      0
`define UFBC_FF_SZ_HI    2
`define UFBC_FF_SZ_LO    1
`define UFBC_FF_STOP     3
`define UFBC_FF_PAR_HI   5
`define UFBC_FF_PAR_LO   4
`define UFBC_FF_MODE_HI  7
`define UFBC_FF_MODE_LO  6
`define UFBC_CB_SZTOP    2
`define UFBC_CB_RX9      1
`define UFBC_CB_TX9      0
`define UFBC_FC_CTS      1
`define UFBC_FC_RTS      0
`define UFBC_SP_DS       0
`define UFBC_CB_WMASK    8'hfd

// oversampling terminal counts (ratio minus one)
`define UFBC_OVS_NORM    4'hf
`define UFBC_OVS_DBL     4'h7
`define UFBC_OVS_SYNC    4'h1

// bus responses
`define UFBC_RESP_OK     2'h0
`define UFBC_RESP_ERR    2'h2

`endif

/* logic/ufbc_pkg.sv */
`include "ufbc_params.svh"

package ufbc_pkg;

	typedef enum logic [1:0] {
		UFBC_ASYNC = 2'h0,
		UFBC_SYNC  = 2'h1,
		UFBC_RSVD  = 2'h2,
		UFBC_SPI   = 2'h3
	} ufbc_mode_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} ufbc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} ufbc_axil_rsp_t;

	typedef struct packed {
		ufbc_mode_t  mode;
		logic [3:0]  data_bits;
		logic        size_rsvd;
		logic [1:0]  parity;
		logic        two_stop;
		logic        tx_ninth_bit;
		logic        double_speed_sel;
	} ufbc_frame_cfg_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic [3:0]  phase;
		logic        tick;
	} ufbc_baud_state_t;

	function automatic logic [3:0] ufbc_char_bits(input logic [2:0] code);
		unique case (code)
			3'h0:    ufbc_char_bits = 4'h5;
			3'h1:    ufbc_char_bits = 4'h6;
			3'h2:    ufbc_char_bits = 4'h7;
			3'h3:    ufbc_char_bits = 4'h8;
			3'h7:    ufbc_char_bits = 4'h9;
			default: ufbc_char_bits = 4'h0;
		endcase
	endfunction : ufbc_char_bits

	function automatic logic ufbc_mapped(input logic [31:0] a);
		ufbc_mapped = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) && (a[7:0] <= `UFBC_OFF_STAT);
	endfunction : ufbc_mapped

endpackage : ufbc_pkg

/* logic/ufbc_baud_gen.sv */
`timescale 1ns/100ps
`include "ufbc_params.svh"

module ufbc_baud_gen (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	// configuration
	input  wire logic [11:0]        baud_divisor,
	input  wire logic               reload,
	input  wire ufbc_pkg::ufbc_mode_t mode,
	input  wire logic               double_speed_sel,
	// bit-rate tick
	output logic                    baud_tick
);
	import ufbc_pkg::*;

	ufbc_baud_state_t st_q;
	ufbc_baud_state_t st_d;
	logic [3:0]       lim;

	always_comb
	begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (mode == UFBC_ASYNC)
			lim = double_speed_sel ? `UFBC_OVS_DBL : `UFBC_OVS_NORM;
		else
			lim = `UFBC_OVS_SYNC;
		if (reload)
		begin
			st_d.cnt = baud_divisor;
			st_d.phase = 4'h0;
		end
		else if (st_q.cnt == 12'h000)
		begin
			st_d.cnt = baud_divisor;
			if (st_q.phase >= lim)
			begin
				st_d.phase = 4'h0;
				st_d.tick = 1'b1;
			end
			else
				st_d.phase = st_q.phase + 4'h1;
		end
		else
			st_d.cnt = st_q.cnt - 12'h001;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign baud_tick = st_q.tick;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	reload_cnt_a: assert property (
		reload |=> st_q.cnt == $past(baud_divisor) && st_q.phase == 4'h0)
		else $error("prescaler not reloaded from divisor");

	tick_cause_a: assert property (
		st_q.tick |-> $past(st_q.cnt) == 12'h000 && $past(st_q.phase) >= $past(lim))
		else $error("tick without full divisor and oversample count");

	ovs_ratio_a: assert property (
		st_q.tick && $past(mode) == UFBC_ASYNC && !$past(double_speed_sel)
		|-> $past(st_q.phase) == `UFBC_OVS_NORM)
		else $error("normal speed oversampling cut short");

endmodule : ufbc_baud_gen

/* bench/ufbc_peer.sv */
`timescale 1ns/100ps
module ufbc_peer (
	// clock
	input  wire logic ref_clk,
	// bench control
	input  wire logic busy,
	input  wire logic run,
	// pins
	output logic      cts_n_pin,
	output logic      sync_clock_pin
);
	logic [2:0] div_q;
	initial
	begin
		div_q = 3'h0;
		sync_clock_pin = 1'b0;
	end
	assign cts_n_pin = busy;
	// clock stands low between frames
	always @(posedge ref_clk)
	begin
		div_q <= run ? div_q + 3'h1 : 3'h0;
		if (!run)
			sync_clock_pin <= 1'b0;
		else if (div_q == 3'h7)
			sync_clock_pin <= ~sync_clock_pin;
	end
endmodule : ufbc_peer

/* bench/uart_frame_flow_baud_config_tb.sv */
`timescale 1ns/100ps
module uart_frame_flow_baud_config_tb;
	import ufbc_pkg::*;
	logic            ref_clk, rstn, busy, run, rx_buf_full;
	logic            cts_n_pin, sync_clock_pin, rts_n_pin, rts_n_oe;
	logic            tx_start_allowed, tx_change_pulse, rx_sample_pulse, baud_tick;
	ufbc_axil_req_t  req;
	ufbc_axil_rsp_t  rsp;
	ufbc_frame_cfg_t frame_cfg;
	int              fail_count, compares;
	logic [31:0]     rd_q;
	logic [1:0]      rr_q;
	logic [1:0]      br_q;

	ufbc_config DUT (.ref_clk(ref_clk), .rstn(rstn), .bus_req(req), .bus_rsp(rsp),
		.cts_n_pin(cts_n_pin), .sync_clock_pin(sync_clock_pin), .rts_n_pin(rts_n_pin),
		.rts_n_oe(rts_n_oe), .rx_buf_full(rx_buf_full), .frame_cfg(frame_cfg),
		.tx_start_allowed(tx_start_allowed), .tx_change_pulse(tx_change_pulse),
		.rx_sample_pulse(rx_sample_pulse), .baud_tick(baud_tick));
	ufbc_peer peer (.ref_clk(ref_clk), .busy(busy), .run(run), .cts_n_pin(cts_n_pin),
		.sync_clock_pin(sync_clock_pin));

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic tmo(input int n);
		if (n > 2000)
		begin
			fail_count++;
			$display("unexpected at %0t: wait ran out", $time);
			stop_test();
		end
	endtask : tmo

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req.awaddr <= {24'h0, a};
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
			n++;
			tmo(n);
		end
		while (!rsp.bvalid);
		br_q = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		req.araddr <= {24'h0, a};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
			n++;
			tmo(n);
		end
		while (!rsp.rvalid);
		rd_q = rsp.rdata;
		rr_q = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd

	task automatic t_reset;
		for (int i = 0; i < 6; i++)
		begin
			rd(8'(i * 4));
			check(rd_q, i == 0 ? 32'h6 : 32'h0);
		end
		rd(8'h1c);
		check(rr_q, 2'h2);
		rd(8'h18);
		check(rd_q, 32'hc8);
		wr(8'h1c, 8'h55);
		check(br_q, 2'h2);
		wr(8'h0c, 8'hfa);
		rd(8'h0c);
		check(rd_q, 32'h0a);
		wr(8'h0c, 8'h00);
		check(br_q, 2'h0);
	endtask : t_reset

	task automatic t_size;
		logic [3:0] exp [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h0, 4'h0, 4'h0, 4'h9};
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h00, 8'(c % 4) << 1);
			wr(8'h04, 8'(c / 4) << 2);
			repeat (2) @(posedge ref_clk);
			check(frame_cfg.data_bits, exp[c]);
			check(frame_cfg.size_rsvd, c > 3 && c < 7);
		end
		wr(8'h04, 8'h03);
		repeat (2) @(posedge ref_clk);
		check(frame_cfg.tx_ninth_bit, 1'b1);
		rd(8'h04);
		check(rd_q, 32'h01);
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h06);
	endtask : t_size

	// reload lands on the edge the write completes: first tick one period plus one edge on
	task automatic period(input int first, input int exp);
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
			tmo(n);
		end
		while (!baud_tick);
		check(n, first);
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
			tmo(n);
		end
		while (!baud_tick);
		check(n, exp);
	endtask : period

	task automatic t_baud;
		wr(8'h10, 8'h02);
		period(49, 48);
		wr(8'h14, 8'h01);
		wr(8'h10, 8'h02);
		period(25, 24);
		check(frame_cfg.double_speed_sel, 1'b1);
		wr(8'h14, 8'h00);
	endtask : t_baud

	task automatic t_flow;
		wr(8'h08, 8'h02);
		busy <= 1'b1;
		repeat (5) @(posedge ref_clk);
		check(tx_start_allowed, 1'b0);
		busy <= 1'b0;
		repeat (5) @(posedge ref_clk);
		check(tx_start_allowed, 1'b1);
		wr(8'h08, 8'h01);
		busy <= 1'b1;
		rx_buf_full <= 1'b1;
		repeat (5) @(posedge ref_clk);
		check(tx_start_allowed, 1'b1);
		check({rts_n_oe, rts_n_pin}, 2'h3);
		rx_buf_full <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check({rts_n_oe, rts_n_pin}, 2'h2);
		wr(8'h08, 8'h00);
		repeat (3) @(posedge ref_clk);
		check(rts_n_oe, 1'b0);
		check(rts_n_pin, 1'b1);
	endtask : t_flow

	task automatic t_sync(input logic [7:0] frame, input logic [1:0] exp);
		logic t, r;
		int n;
		n = 0;
		t = 1'b0;
		r = 1'b0;
		wr(8'h00, frame);
		run <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
			tmo(n);
		end
		while (!sync_clock_pin);
		check(frame_cfg.mode, frame[7:6]);
		repeat (6)
		begin
			@(posedge ref_clk);
			t |= tx_change_pulse;
			r |= rx_sample_pulse;
		end
		check({t, r}, exp);
		run <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask : t_sync

	initial
	begin
		req = '0;
		rstn = 1'b0;
		busy = 1'b0;
		run = 1'b0;
		rx_buf_full = 1'b0;
		fail_count = 0;
		compares = 0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset();
		t_size();
		t_baud();
		t_flow();
		t_sync(8'h46, 2'h2);
		t_sync(8'h47, 2'h1);
		t_sync(8'h06, 2'h0);
		t_sync(8'hc6, 2'h0);
		stop_test();
	end
endmodule : uart_frame_flow_baud_config_tb
